// ---- shared/rmsp_pkg.sv ----
// Shared constants for the radio modem serial port
package rmsp_pkg;
	localparam int RMSP_BITS = 8;
	localparam logic [2:0] RMSP_BIT_LAST = 3'h7;
	localparam logic [2:0] RMSP_BIT_ZERO = 3'h0;
	localparam int RMSP_ADDR_W = 6;
	localparam int RMSP_HDR_RW_BIT = 7;
	localparam logic [7:0] RMSP_CNT_MAX = 8'hFF;
	localparam logic [7:0] RMSP_MIN_PAYLOAD = 8'h02;
	localparam real RMSP_CLK_MHZ = 20.0;
	localparam real RMSP_SCLK_MAX_MHZ = 8.0;
	// Host half period in core cycles; least time rounds up
	localparam int RMSP_HALF_CYC_CALC = int'($ceil(RMSP_CLK_MHZ / (2.0 * RMSP_SCLK_MAX_MHZ)));
	localparam logic [3:0] RMSP_HALF_CYC = 4'(RMSP_HALF_CYC_CALC < 1 ? 1 : RMSP_HALF_CYC_CALC);
	localparam logic [3:0] RMSP_ZERO4 = 4'h0;
	localparam logic [7:0] RMSP_ZERO8 = 8'h00;
	localparam logic [7:0] RMSP_ONE8 = 8'h01;
	localparam logic [2:0] RMSP_ONE3 = 3'h1;
endpackage : rmsp_pkg

// ---- shared/rmsp_if.sv ----
// Four-wire link between host master and modem slave
`timescale 1ns/100ps
interface rmsp_if;
	logic serial_clock_in;
	logic mosi;
	logic frame_n;
	logic miso_o;
	logic miso_oe_n;
	logic miso;
	assign miso = miso_oe_n ? 1'b1 : miso_o;
	modport dev (input serial_clock_in, input mosi, input frame_n, output miso_o, output miso_oe_n);
	modport host (output serial_clock_in, output mosi, output frame_n, input miso);
endinterface : rmsp_if

// ---- rtl/rmsp_slave.sv ----
// Modem end of the serial command port
// Overview of operation
// - Slave only, never drives clock
// - Frame low starts and spans transaction
// - Host raises frame after last burst
// - At least three bursts per transaction
// - Sample rising edge, change on falling
// - Clock idles low, first edge samples
// - Eight bits per burst, MSB first
// - Serial clock at most 8 MHz
// - Header holds address and read flag
// - Payload flows one direction only
// - Payload at least two bytes
// - Core clock moves words to registers
// - Float or drive low MISO when idle
// - No response while port disabled
`timescale 1ns/100ps
module rmsp_slave
	import rmsp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Link
	rmsp_if.dev lnk,
	// Control
	input wire logic port_en_i,
	input wire logic miso_float_en_i,
	// Core register side
	output logic [RMSP_ADDR_W-1:0] addr_o,
	output logic rd_o,
	output logic hdr_valid_o,
	output logic [RMSP_BITS-1:0] wdata_o,
	output logic wr_valid_o,
	input wire logic [RMSP_BITS-1:0] rdata_i,
	output logic rd_req_o,
	output logic frame_end_o,
	output logic short_o
);
	typedef struct packed {
		logic sck_d;
		logic frm_d;
		logic [2:0] bit_cnt;
		logic [7:0] burst_cnt;
		logic [7:0] sh_in;
		logic [7:0] sh_out;
		logic miso;
		logic [5:0] addr;
		logic rd;
		logic hdr_v;
		logic [7:0] wdata;
		logic wr_v;
		logic rd_req;
		logic fend;
		logic short_f;
		logic active;
	} rmsp_st_t;
	rmsp_st_t st_r;
	rmsp_st_t st_nxt;
	logic rise;
	logic fall;
	logic [7:0] shifted;
	assign rise = lnk.serial_clock_in & ~st_r.sck_d;
	assign fall = ~lnk.serial_clock_in & st_r.sck_d;
	assign shifted = {st_r.sh_in[6:0], lnk.mosi};
	always_comb begin
		st_nxt = st_r;
		st_nxt.sck_d = lnk.serial_clock_in;
		st_nxt.frm_d = lnk.frame_n;
		st_nxt.hdr_v = 1'b0;
		st_nxt.wr_v = 1'b0;
		st_nxt.rd_req = 1'b0;
		st_nxt.fend = 1'b0;
		if (lnk.frame_n || !port_en_i) begin
			st_nxt.bit_cnt = RMSP_BIT_ZERO;
			st_nxt.burst_cnt = RMSP_ZERO8;
			st_nxt.miso = 1'b0;
			st_nxt.active = 1'b0;
			if (st_r.active) begin
				st_nxt.fend = 1'b1;
				st_nxt.short_f = (st_r.burst_cnt < (RMSP_MIN_PAYLOAD + RMSP_ONE8));
			end
		end else begin
			if (st_r.frm_d) begin
				st_nxt.active = 1'b1;
				st_nxt.bit_cnt = RMSP_BIT_ZERO;
				st_nxt.burst_cnt = RMSP_ZERO8;
			end
			if (rise) begin
				st_nxt.sh_in = shifted;
				st_nxt.bit_cnt = st_r.bit_cnt + RMSP_ONE3;
				if (st_r.bit_cnt == RMSP_BIT_LAST) begin
					if (st_r.burst_cnt != RMSP_CNT_MAX) begin
						st_nxt.burst_cnt = st_r.burst_cnt + RMSP_ONE8;
					end
					if (st_r.burst_cnt == RMSP_ZERO8) begin
						st_nxt.addr = shifted[RMSP_ADDR_W-1:0];
						st_nxt.rd = shifted[RMSP_HDR_RW_BIT];
						st_nxt.hdr_v = 1'b1;
						st_nxt.rd_req = shifted[RMSP_HDR_RW_BIT];
					end else if (!st_r.rd) begin
						st_nxt.wdata = shifted;
						st_nxt.wr_v = 1'b1;
					end else begin
						st_nxt.rd_req = 1'b1;
					end
				end
			end
			if (fall) begin
				if (st_r.bit_cnt == RMSP_BIT_ZERO) begin
					st_nxt.sh_out = {rdata_i[6:0], 1'b0};
					st_nxt.miso = st_r.rd & (st_r.burst_cnt != RMSP_ZERO8) & rdata_i[7];
				end else begin
					st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
					st_nxt.miso = st_r.rd & st_r.sh_out[7];
				end
			end
		end
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
			st_r.frm_d <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	// Slave never drives clock or frame; MISO floats or idles low
	assign lnk.miso_o = st_r.miso;
	assign lnk.miso_oe_n = (lnk.frame_n || !port_en_i) ? miso_float_en_i : 1'b0;
	assign addr_o = st_r.addr;
	assign rd_o = st_r.rd;
	assign hdr_valid_o = st_r.hdr_v;
	assign wdata_o = st_r.wdata;
	assign wr_valid_o = st_r.wr_v;
	assign rd_req_o = st_r.rd_req;
	assign frame_end_o = st_r.fend;
	assign short_o = st_r.short_f;
endmodule : rmsp_slave

// ---- rtl/rmsp_master.sv ----
// Host end of the serial command port
`timescale 1ns/100ps
module rmsp_master
	import rmsp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Link
	rmsp_if.host lnk,
	// User command
	input wire logic start_i,
	input wire logic rd_i,
	input wire logic [RMSP_ADDR_W-1:0] addr_i,
	input wire logic [7:0] nbytes_i,
	input wire logic [RMSP_BITS-1:0] wdata_i,
	output logic wdata_take_o,
	output logic [RMSP_BITS-1:0] rdata_o,
	output logic rdata_valid_o,
	output logic busy_o,
	output logic done_o
);
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_SHIFT = 2'b01, S_END = 2'b11} rmsp_hst_t;
	typedef struct packed {
		rmsp_hst_t state;
		logic [3:0] div;
		logic sck;
		logic frm_n;
		logic mosi;
		logic [2:0] bit_cnt;
		logic [7:0] left;
		logic [7:0] sh;
		logic rd;
		logic hdr;
		logic [7:0] rdata;
		logic rv;
		logic take;
		logic done;
	} rmsp_hreg_t;
	rmsp_hreg_t st_r;
	rmsp_hreg_t st_nxt;
	logic tick;
	logic [7:0] nb;
	assign tick = (st_r.div == RMSP_ZERO4);
	// Payload length floored at two bytes
	assign nb = (nbytes_i < RMSP_MIN_PAYLOAD) ? RMSP_MIN_PAYLOAD : nbytes_i;
	always_comb begin
		st_nxt = st_r;
		st_nxt.rv = 1'b0;
		st_nxt.take = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.div = tick ? (RMSP_HALF_CYC - 4'h1) : (st_r.div - 4'h1);
		unique case (st_r.state)
			S_IDLE: begin
				st_nxt.sck = 1'b0;
				st_nxt.frm_n = 1'b1;
				if (start_i) begin
					st_nxt.state = S_SHIFT;
					st_nxt.frm_n = 1'b0;
					st_nxt.rd = rd_i;
					st_nxt.hdr = 1'b1;
					st_nxt.left = nb;
					st_nxt.sh = {rd_i, 1'b0, addr_i};
					st_nxt.mosi = rd_i;
					st_nxt.bit_cnt = RMSP_BIT_ZERO;
					st_nxt.div = RMSP_HALF_CYC - 4'h1;
				end
			end
			S_SHIFT: begin
				if (tick) begin
					st_nxt.sck = ~st_r.sck;
					if (!st_r.sck) begin
						st_nxt.rdata = {st_r.rdata[6:0], lnk.miso};
					end else begin
						st_nxt.bit_cnt = st_r.bit_cnt + RMSP_ONE3;
						if (st_r.bit_cnt == RMSP_BIT_LAST) begin
							st_nxt.hdr = 1'b0;
							if (!st_r.hdr) begin
								st_nxt.left = st_r.left - RMSP_ONE8;
								st_nxt.rv = st_r.rd;
							end
							if (!st_r.hdr && st_r.left == RMSP_ONE8) begin
								st_nxt.state = S_END;
								st_nxt.mosi = 1'b0;
							end else begin
								st_nxt.sh = st_r.rd ? RMSP_ZERO8 : wdata_i;
								st_nxt.take = ~st_r.rd;
								st_nxt.mosi = st_r.rd ? 1'b0 : wdata_i[7];
							end
						end else begin
							st_nxt.sh = {st_r.sh[6:0], 1'b0};
							st_nxt.mosi = st_r.sh[6];
						end
					end
				end
			end
			S_END: begin
				if (tick) begin
					st_nxt.frm_n = 1'b1;
					st_nxt.state = S_IDLE;
					st_nxt.done = 1'b1;
				end
			end
			default: st_nxt.state = S_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
			st_r.frm_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign lnk.serial_clock_in = st_r.sck;
	assign lnk.frame_n = st_r.frm_n;
	assign lnk.mosi = st_r.mosi;
	assign wdata_take_o = st_r.take;
	assign rdata_o = st_r.rdata;
	assign rdata_valid_o = st_r.rv;
	assign busy_o = (st_r.state != S_IDLE);
	assign done_o = st_r.done;
endmodule : rmsp_master

// ---- dv/rmsp_props.sv ----
// Link protocol checks for the serial command port
`timescale 1ns/100ps
module rmsp_props (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Link
	input wire logic serial_clock_in,
	input wire logic mosi,
	input wire logic frame_n,
	input wire logic miso_o,
	input wire logic miso_oe_n
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [11:0] edges_r;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) edges_r <= 12'h000;
		else if (frame_n) edges_r <= 12'h000;
		else if ($rose(serial_clock_in)) edges_r <= edges_r + 12'h001;
	end
	chk_clk_idle_low: assert property (frame_n |-> !serial_clock_in)
		else $error("clock high outside frame");
	chk_frame_start: assert property ($fell(frame_n) |-> (!serial_clock_in) [*2])
		else $error("clock not low at frame start");
	chk_mosi_stable: assert property (serial_clock_in |-> $stable(mosi))
		else $error("mosi moved while clock high");
	chk_miso_stable: assert property (!frame_n && serial_clock_in && $past(serial_clock_in)
		|-> $stable(miso_o))
		else $error("miso moved while clock high");
	chk_sck_high: assert property ($rose(serial_clock_in) |=> serial_clock_in ##1
		!serial_clock_in)
		else $error("clock high time wrong");
	chk_sck_low: assert property ($fell(serial_clock_in) && !frame_n |=> !serial_clock_in)
		else $error("clock low time short");
	chk_frame_end: assert property ($rose(frame_n) |-> !$past(serial_clock_in)
		&& !$past(serial_clock_in, 2))
		else $error("frame ended early");
	chk_burst_count: assert property ($rose(frame_n) |-> edges_r[2:0] == 3'h0
		&& edges_r >= 12'h018)
		else $error("bad burst count");
	cover property ($rose(frame_n));
	cover property (!frame_n && !miso_oe_n && miso_o);
	cover property ($rose(frame_n) && edges_r > 12'h018);
endmodule : rmsp_props

// ---- dv/rmsp_tb.sv ----
// Bench joining host and modem ends of the serial port
`timescale 1ns/100ps
module rmsp_tb;
	import rmsp_pkg::*;
	logic clk, rstn, port_en, float_en, start, rd, s_rd, hdr_v, wr_v, rdv, done;
	logic fend, rd_req, take, busy;
	logic [5:0] addr, s_addr;
	logic [7:0] nbytes, wdata, rdata_in, rdata, s_wdata;
	logic short_f;
	int errors, n_checks, nh, nw, nr, nf, nq, nt;
	// Read flag, address, bytes asked, data, bytes expected
	logic [30:0] rows [4] = '{{1'h0, 6'h3F, 8'h02, 8'hA5, 8'h02},
		{1'h1, 6'h00, 8'h03, 8'h5A, 8'h03}, {1'h0, 6'h15, 8'h00, 8'h81, 8'h02},
		{1'h1, 6'h2A, 8'h01, 8'hC3, 8'h02}};
	rmsp_if lnk();
	rmsp_slave rmsp_slave_inst (.ref_clk_i(clk), .rstn_i(rstn), .lnk(lnk), .port_en_i(port_en),
		.miso_float_en_i(float_en), .addr_o(s_addr), .rd_o(s_rd), .hdr_valid_o(hdr_v),
		.wdata_o(s_wdata), .wr_valid_o(wr_v), .rdata_i(rdata_in), .rd_req_o(rd_req),
		.frame_end_o(fend), .short_o(short_f));
	rmsp_master rmsp_master_inst (.ref_clk_i(clk), .rstn_i(rstn), .lnk(lnk), .start_i(start),
		.rd_i(rd), .addr_i(addr), .nbytes_i(nbytes), .wdata_i(wdata), .wdata_take_o(take),
		.rdata_o(rdata), .rdata_valid_o(rdv), .busy_o(busy), .done_o(done));
	rmsp_props rmsp_props_inst (.ref_clk_i(clk), .rstn_i(rstn),
		.serial_clock_in(lnk.serial_clock_in), .mosi(lnk.mosi), .frame_n(lnk.frame_n),
		.miso_o(lnk.miso_o), .miso_oe_n(lnk.miso_oe_n));
	always @(posedge clk) begin
		if (hdr_v === 1'b1) nh++;
		if (rd_req === 1'b1) nq++;
		if (take === 1'b1) nt++;
		if (wr_v === 1'b1) nw++;
		if (rdv === 1'b1) nr++;
		if (fend === 1'b1) nf++;
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	task automatic run(input logic [30:0] r);
		int k;
		{rd, addr, nbytes, rdata_in} = r[30:8];
		wdata = r[15:8];
		nh = 0;
		nw = 0;
		nr = 0;
		nf = 0;
		nq = 0;
		nt = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk(16'(busy), 16'h0001);
		k = 0;
		while (done !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 3000) begin
			errors++;
			close_out();
		end
		repeat (3) @(negedge clk);
	endtask : run
	initial begin
		{rstn, port_en, float_en, start, rd, addr, nbytes, wdata, rdata_in} = '0;
		port_en = 1'b1;
		float_en = 1'b1;
		@(negedge clk);
		chk(16'(lnk.frame_n), 16'h0001);
		chk(16'(lnk.miso), 16'h0001);
		@(negedge clk);
		rstn = 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
			chk(16'(s_addr), 16'(rows[i][29:24]));
			chk(16'(s_rd), 16'(rows[i][30]));
			chk(16'(nh), 16'h0001);
			chk(16'(nf), 16'h0001);
			chk(16'(short_f), 16'h0000);
			chk(16'(rows[i][30] ? nr : nw), 16'(rows[i][7:0]));
			chk(16'(rows[i][30] ? nw : nr), 16'h0000);
			chk(16'(rows[i][30] ? rdata : s_wdata), 16'(rows[i][15:8]));
			chk(16'(nq), rows[i][30] ? 16'(rows[i][7:0]) + 16'h0001 : 16'h0000);
			chk(16'(nt), rows[i][30] ? 16'h0000 : 16'(rows[i][7:0]));
			chk(16'(busy), 16'h0000);
		end
		float_en = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'(lnk.miso), 16'h0000);
		port_en = 1'b0;
		run(rows[0]);
		chk(16'(nh), 16'h0000);
		chk(16'(nw), 16'h0000);
		close_out();
	end
endmodule : rmsp_tb
